// ===== power_monitor_adc_sequencer.v
`timescale 1ns/1ps
`include "pmon_map.vh"

// Operation
// - 12-bit result split high byte, low nibble
// - Low result byte bottom nibble reads zero
// - Results written right after each conversion
// - Scan order: current, supply, auxiliary input
// - Snapshot requested by one control byte write
// - Snapshot starts after write, busy set
// - Snapshot done: halt, busy cleared
// - Either supply up enables bus and converter
// - Both supplies down disable converter, bus
// - Shutdown bit powers down converter, reference
// - Shutdown keeps bus, freezes latched address
// - Registers stay readable, writable in shutdown
// - Clearing shutdown resumes, registers kept
// - Regulator enable low during shutdown
// - Voltage select bits pick power voltage
// - Power is 24-bit current times voltage
// - Power step equals voltage times current step
// - Power product spans three result registers
// - Power undefined at reset, scan-only update
// - Step 25mV supply, 0.5mV auxiliary
module power_monitor_adc_sequencer (
    // Clock, reset, enable
    input wire core_clk,
    input wire sys_rst,
    input wire clkEn,
    // Serial bus pins
    input wire scl,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    // Address select pins, coded 0 low, 1 open, 2 high
    input wire [1:0] addressSelectPinHigh,
    input wire [1:0] addressSelectPinLow,
    // Supply threshold comparators
    input wire highSupplyUvOk,
    input wire lowSupplyRailUvOk,
    input wire highSupplyBusOk,
    input wire lowSupplyRailBusOk,
    // Converter
    output wire adcStart,
    output wire [1:0] adcChannel,
    output wire adcSupplySense,
    input wire adcDone,
    input wire [11:0] adcData,
    // Analog power controls
    output wire adcEnable,
    output wire refEnable,
    output wire regulatorEnable
);

    localparam I_IDLE = 4'h0;
    localparam I_ADDR = 4'h1;
    localparam I_ADDR_ACK = 4'h2;
    localparam I_CMD = 4'h3;
    localparam I_CMD_ACK = 4'h4;
    localparam I_WR = 4'h5;
    localparam I_WR_ACK = 4'h6;
    localparam I_RD = 4'h7;
    localparam I_RD_ACK = 4'h8;
    localparam S_IDLE = 2'h0;
    localparam S_CONV = 2'h1;
    localparam S_WRITE = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // High result register of a channel
    function [5:0] chanHighAddr;
        input [1:0] ch;
        begin
            if (ch == `CH_CURRENT)
                chanHighAddr = `REG_CURRENT_HIGH;
            else if (ch == `CH_SUPPLY)
                chanHighAddr = `REG_SUPPLY_HIGH;
            else
                chanHighAddr = `REG_AUX_HIGH;
        end
    endfunction

    // Pointer increment with wrap
    function [5:0] nextPtr;
        input [5:0] p;
        begin
            nextPtr = (p == `PTR_WRAP) ? `PTR_ZERO : p + `PTR_STEP;
        end
    endfunction

    // Low result bytes keep a zero bottom nibble
    function isLowReg;
        input [5:0] a;
        begin
            isLowReg = (a == chanHighAddr(`CH_CURRENT) + `PTR_STEP) ||
                (a == chanHighAddr(`CH_SUPPLY) + `PTR_STEP) ||
                (a == chanHighAddr(`CH_AUX) + `PTR_STEP);
        end
    endfunction

    // Snapshot code to channel
    function [1:0] decodeSnap;
        input [1:0] code;
        begin
            if (code == `SNAP_CODE_SUPPLY)
                decodeSnap = `CH_SUPPLY;
            else if (code == `SNAP_CODE_AUX)
                decodeSnap = `CH_AUX;
            else
                decodeSnap = `CH_CURRENT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers and bus edges

    wire [9:0] asyncIn = {scl, sdaIn, highSupplyUvOk, lowSupplyRailUvOk,
        highSupplyBusOk, lowSupplyRailBusOk, addressSelectPinHigh,
        addressSelectPinLow};
    reg [9:0] syncA_q;
    reg [9:0] syncB_q;
    reg sclPrev_q;
    reg sdaPrev_q;

    // Two stages per pin; logic reads only the second
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            syncA_q <= 10'h000;
            syncB_q <= 10'h000;
            sclPrev_q <= 1'b0;
            sdaPrev_q <= 1'b0;
        end
        else if (clkEn)
        begin
            syncA_q <= asyncIn;
            syncB_q <= syncA_q;
            sclPrev_q <= syncB_q[9];
            sdaPrev_q <= syncB_q[8];
        end
    end

    wire sclS = syncB_q[9];
    wire sdaS = syncB_q[8];
    wire uvAny = syncB_q[7] | syncB_q[6];
    wire busAny = syncB_q[5] | syncB_q[4];
    wire sclRise = sclS & ~sclPrev_q;
    wire sclFall = ~sclS & sclPrev_q;
    wire startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    wire stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    ////////////////////////////////////////////////////////////////////////
    // Supply lockout

    reg busRun_q;
    reg [7:0] ctrl_q;
    reg [3:0] addrLow_q;
    wire shutdown = ctrl_q[`CTRL_SHUTDOWN];
    wire busLogicRst = sys_rst | ~busRun_q;
    wire [3:0] pinCode = {2'b00, syncB_q[3:2]} + {1'b0, syncB_q[3:2], 1'b0}
        + {2'b00, syncB_q[1:0]};

    // Either supply starts the bus; both below bus level stop it
    always @(posedge core_clk)
    begin
        if (sys_rst)
            busRun_q <= 1'b0;
        else if (clkEn && uvAny)
            busRun_q <= 1'b1;
        else if (clkEn && !busAny)
            busRun_q <= 1'b0;
    end

    assign adcEnable = busRun_q & uvAny & ~shutdown;
    assign refEnable = ~shutdown;
    assign regulatorEnable = ~shutdown;

    // Address pins are ignored while in shutdown
    always @(posedge core_clk)
    begin
        if (sys_rst)
            addrLow_q <= 4'h0;
        else if (clkEn && !shutdown)
            addrLow_q <= pinCode;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial bus slave

    reg [3:0] iState_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg rnw_q;
    reg mAck_q;
    reg [5:0] ptr_q;
    reg sdaOe_q;
    reg snapArm_q;
    reg snapReq_q;
    reg busy_q;
    wire [7:0] memRData;
    wire byteDone = (bitCnt_q == `BYTE_BITS);
    wire busWr = clkEn & sclFall & (iState_q == I_WR) & byteDone;
    wire busIsMem = (ptr_q != `REG_CONTROL) && (ptr_q <= `REG_LAST_MAPPED);
    wire [7:0] busData = isLowReg(ptr_q) ?
        {shift_q[7:4], `LOW_NIBBLE_ZERO} : shift_q;
    wire [7:0] ctrlView = {ctrl_q[7:4], busy_q, ctrl_q[2:0]};
    wire [7:0] rdByte = (ptr_q == `REG_CONTROL) ? ctrlView :
        (busIsMem ? memRData : 8'h00);

    // Runs in shutdown; only sys_rst or the lockout resets it
    always @(posedge core_clk)
    begin
        if (busLogicRst)
        begin
            iState_q <= I_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            rnw_q <= 1'b0;
            mAck_q <= 1'b0;
            ptr_q <= `PTR_ZERO;
            sdaOe_q <= 1'b0;
            snapArm_q <= 1'b0;
            snapReq_q <= 1'b0;
            ctrl_q <= `CTRL_RESET;
        end
        else if (clkEn)
        begin
            snapReq_q <= 1'b0;
            if (startCond)
            begin
                iState_q <= I_ADDR;
                bitCnt_q <= 4'h0;
                sdaOe_q <= 1'b0;
            end
            else if (stopCond)
            begin
                iState_q <= I_IDLE;
                sdaOe_q <= 1'b0;
                ptr_q <= `PTR_ZERO;
                snapReq_q <= snapArm_q;
                snapArm_q <= 1'b0;
            end
            else if (sclRise)
            begin
                if (iState_q == I_ADDR || iState_q == I_CMD ||
                    iState_q == I_WR)
                begin
                    shift_q <= {shift_q[6:0], sdaS};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                else if (iState_q == I_RD)
                    bitCnt_q <= bitCnt_q + 4'h1;
                else if (iState_q == I_RD_ACK)
                    mAck_q <= ~sdaS;
            end
            else if (sclFall)
            begin
                case (iState_q)
                    I_ADDR:
                        if (byteDone)
                        begin
                            bitCnt_q <= 4'h0;
                            rnw_q <= shift_q[0];
                            if (shift_q[7:1] == {`I2C_ADDR_TOP, addrLow_q})
                            begin
                                sdaOe_q <= 1'b1;
                                iState_q <= I_ADDR_ACK;
                            end
                            else
                                iState_q <= I_IDLE;
                        end
                    I_ADDR_ACK, I_RD_ACK:
                        if (iState_q == I_RD_ACK && !mAck_q)
                        begin
                            sdaOe_q <= 1'b0;
                            iState_q <= I_IDLE;
                        end
                        else if (iState_q == I_RD_ACK || rnw_q)
                        begin
                            // First bit goes out on this same edge
                            sdaOe_q <= ~rdByte[7];
                            shift_q <= {rdByte[6:0], 1'b1};
                            bitCnt_q <= 4'h0;
                            iState_q <= I_RD;
                        end
                        else
                        begin
                            sdaOe_q <= 1'b0;
                            iState_q <= I_CMD;
                        end
                    I_CMD:
                        if (byteDone)
                        begin
                            ptr_q <= shift_q[5:0];
                            sdaOe_q <= 1'b1;
                            iState_q <= I_CMD_ACK;
                        end
                    I_CMD_ACK, I_WR_ACK:
                    begin
                        sdaOe_q <= 1'b0;
                        bitCnt_q <= 4'h0;
                        iState_q <= I_WR;
                        if (iState_q == I_WR_ACK)
                            ptr_q <= nextPtr(ptr_q);
                    end
                    I_WR:
                        if (byteDone)
                        begin
                            sdaOe_q <= 1'b1;
                            iState_q <= I_WR_ACK;
                            if (ptr_q == `REG_CONTROL)
                            begin
                                // Busy is read-only; its stored bit is kept
                                ctrl_q <= {shift_q[7:4], ctrl_q[3],
                                    shift_q[2:0]};
                                snapArm_q <= shift_q[`CTRL_SNAP_EN];
                            end
                        end
                    I_RD:
                        if (byteDone)
                        begin
                            sdaOe_q <= 1'b0;
                            ptr_q <= nextPtr(ptr_q);
                            iState_q <= I_RD_ACK;
                        end
                        else
                        begin
                            sdaOe_q <= ~shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b1};
                        end
                    default:
                        iState_q <= I_IDLE;
                endcase
            end
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_q;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    reg [1:0] sState_q;
    reg [1:0] ch_q;
    reg [1:0] scanCh_q;
    reg snapJob_q;
    reg powerJob_q;
    reg snapPend_q;
    reg [2:0] wrIdx_q;
    reg adcStart_q;
    reg [11:0] convVal_q;
    reg [11:0] curVal_q;
    reg [11:0] supVal_q;
    reg [11:0] auxVal_q;
    wire [23:0] product;
    wire [1:0] vsel = {ctrl_q[`CTRL_VSEL_HI], ctrl_q[`CTRL_VSEL_LO]};
    wire [11:0] pwrVolt = (vsel == `VSEL_AUX) ? auxVal_q : supVal_q;
    wire [2:0] lastIdx = powerJob_q ? `WR_IDX_LAST : `WR_IDX_LOW;
    wire seqWe = (sState_q == S_WRITE) & ~busWr;
    wire multStart = (sState_q == S_WRITE) & (wrIdx_q == 3'h0) & powerJob_q;
    reg [7:0] seqByte;
    wire [5:0] seqAddr = (wrIdx_q < `WR_IDX_PWR) ?
        chanHighAddr(ch_q) + {5'h00, wrIdx_q[0]} :
        `REG_POWER_HIGH + {3'h0, wrIdx_q} - `POWER_BASE_SHIFT;

    // Byte to store; raw 25mV or 0.5mV steps
    always @*
    begin
        case (wrIdx_q)
            3'h0: seqByte = convVal_q[11:4];
            3'h1: seqByte = {convVal_q[3:0], `LOW_NIBBLE_ZERO};
            3'h2: seqByte = product[23:16];
            3'h3: seqByte = product[15:8];
            default: seqByte = product[7:0];
        endcase
    end

    // Sense-high measured unless high supply picked
    assign adcSupplySense = (vsel != `VSEL_SUPPLY);

    // Scan loops; a snapshot runs once and halts
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sState_q <= S_IDLE;
            ch_q <= `CH_CURRENT;
            scanCh_q <= `CH_CURRENT;
            snapJob_q <= 1'b0;
            powerJob_q <= 1'b0;
            snapPend_q <= 1'b0;
            wrIdx_q <= 3'h0;
            adcStart_q <= 1'b0;
            busy_q <= 1'b0;
            convVal_q <= 12'h000;
            curVal_q <= 12'h000;
            supVal_q <= 12'h000;
            auxVal_q <= 12'h000;
        end
        else if (clkEn)
        begin
            adcStart_q <= 1'b0;
            case (sState_q)
                S_IDLE:
                    if (adcEnable && (snapPend_q ||
                        !ctrl_q[`CTRL_SNAP_EN]))
                    begin
                        adcStart_q <= 1'b1;
                        sState_q <= S_CONV;
                        snapJob_q <= snapPend_q;
                        if (snapPend_q)
                        begin
                            ch_q <= decodeSnap(ctrl_q[6:5]);
                            busy_q <= 1'b1;
                            powerJob_q <= 1'b0;
                            snapPend_q <= 1'b0;
                        end
                        else
                        begin
                            ch_q <= scanCh_q;
                            powerJob_q <= (scanCh_q == `CH_AUX);
                        end
                    end
                S_CONV:
                    if (!adcEnable)
                    begin
                        // Shutdown or lockout abandons the conversion
                        sState_q <= S_IDLE;
                        busy_q <= 1'b0;
                    end
                    else if (adcDone)
                    begin
                        convVal_q <= adcData;
                        if (ch_q == `CH_CURRENT)
                            curVal_q <= adcData;
                        else if (ch_q == `CH_SUPPLY)
                            supVal_q <= adcData;
                        else
                            auxVal_q <= adcData;
                        wrIdx_q <= 3'h0;
                        sState_q <= S_WRITE;
                    end
                default:
                    // A bus write owns the memory port; wait
                    if (!busWr)
                    begin
                        if (wrIdx_q == lastIdx)
                        begin
                            sState_q <= S_IDLE;
                            busy_q <= 1'b0;
                            if (!snapJob_q)
                                scanCh_q <= (scanCh_q == `CH_AUX) ?
                                    `CH_CURRENT : scanCh_q + 2'h1;
                        end
                        else
                            wrIdx_q <= wrIdx_q + 3'h1;
                    end
            endcase
            // Request arriving with a take still wins
            if (snapReq_q)
                snapPend_q <= 1'b1;
        end
    end

    assign adcStart = adcStart_q;
    assign adcChannel = ch_q;

    ////////////////////////////////////////////////////////////////////////
    // Result store and power multiplier

    pmon_reg_mem u_mem (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .we((busWr & busIsMem) | seqWe),
        .wAddr(busWr ? ptr_q[3:0] : seqAddr[3:0]),
        .wData(busWr ? busData : seqByte),
        .rAddr(ptr_q[3:0]),
        .rData(memRData)
    );

    pmon_power_mult u_mult (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .start(multStart),
        .currentCode(curVal_q),
        .voltageCode(pwrVolt),
        .product(product)
    );

endmodule

// ===== pmon_map.vh
`ifndef PMON_MAP_VH
`define PMON_MAP_VH

////////////////////////////////////////////////////////////////////////////
// Register pointers
`define REG_CONTROL 6'h00
`define REG_POWER_HIGH 6'h01
`define REG_CURRENT_HIGH 6'h04
`define REG_SUPPLY_HIGH 6'h06
`define REG_AUX_HIGH 6'h08
`define REG_LAST_MAPPED 6'h09
`define PTR_WRAP 6'h31
`define PTR_ZERO 6'h00
`define PTR_STEP 6'h01
`define POWER_BASE_SHIFT 6'h02

////////////////////////////////////////////////////////////////////////////
// Control fields, reset value
`define CTRL_SNAP_EN 7
`define CTRL_SNAP_CH_HI 6
`define CTRL_SNAP_CH_LO 5
`define CTRL_BUSY 3
`define CTRL_VSEL_HI 2
`define CTRL_SHUTDOWN 1
`define CTRL_VSEL_LO 0
`define CTRL_RESET 8'h05

////////////////////////////////////////////////////////////////////////////
// Select, channel and snapshot codes
`define VSEL_SUPPLY 2'h1
`define VSEL_AUX 2'h2
`define CH_CURRENT 2'h0
`define CH_SUPPLY 2'h1
`define CH_AUX 2'h2
`define SNAP_CODE_CURRENT 2'h0
`define SNAP_CODE_SUPPLY 2'h1
`define SNAP_CODE_AUX 2'h2

////////////////////////////////////////////////////////////////////////////
// Step sizes in microvolts, full scale
`define SUPPLY_STEP_UV 25000
`define AUX_STEP_UV 500
`define FULL_SCALE_STEPS 4096

////////////////////////////////////////////////////////////////////////////
// Bus and write sequence
`define I2C_ADDR_TOP 3'h6
`define BYTE_BITS 4'h8
`define LOW_NIBBLE_ZERO 4'h0
`define WR_IDX_LOW 3'h1
`define WR_IDX_PWR 3'h2
`define WR_IDX_LAST 3'h4
`define MEM_AW 4
`define MEM_DEPTH 16

`endif

// ===== pmon_reg_mem.v
`timescale 1ns/1ps
`include "pmon_map.vh"

module pmon_reg_mem (
    // Clock, reset, enable
    input wire core_clk,
    input wire sys_rst,
    input wire clkEn,
    // Write port
    input wire we,
    input wire [`MEM_AW-1:0] wAddr,
    input wire [7:0] wData,
    // Read port
    input wire [`MEM_AW-1:0] rAddr,
    output wire [7:0] rData
);

    reg [7:0] store [0:`MEM_DEPTH-1];
    reg [7:0] rData_q;

    // No reset: power bytes undefined until written
    always @(posedge core_clk)
    begin
        if (clkEn && we)
        begin
            store[wAddr] <= wData;
        end
    end

    // Registered read data
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rData_q <= 8'h00;
        end
        else if (clkEn)
        begin
            rData_q <= store[rAddr];
        end
    end

    assign rData = rData_q;

endmodule

// ===== pmon_power_mult.v
`timescale 1ns/1ps
`include "pmon_map.vh"

module pmon_power_mult (
    // Clock, reset, enable
    input wire core_clk,
    input wire sys_rst,
    input wire clkEn,
    // Operands
    input wire start,
    input wire [11:0] currentCode,
    input wire [11:0] voltageCode,
    // Result
    output wire [23:0] product
);

    reg [23:0] product_q;

    // Unsigned product, no shift or rounding
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            product_q <= 24'h00_0000;
        end
        else if (clkEn && start)
        begin
            product_q <= currentCode * voltageCode;
        end
    end

    assign product = product_q;

endmodule

// ===== pmon_props.sv
`timescale 1ns/1ps
module pmon_props (
    // Clock and reset
    input logic core_clk,
    input logic sys_rst,
    // Bus and supply inputs
    input logic scl,
    input logic sdaOe,
    input logic highSupplyUvOk,
    input logic lowSupplyRailUvOk,
    // Converter and analog power
    input logic adcStart,
    input logic [1:0] adcChannel,
    input logic adcEnable,
    input logic refEnable,
    input logic regulatorEnable
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Shutdown drops all analog power
    property p_reg; regulatorEnable == refEnable; endproperty
    a_reg: assert property (p_reg)
        else $error("regulator differs from reference");
    property p_ref; !refEnable |-> !adcEnable; endproperty
    a_ref: assert property (p_ref)
        else $error("converter on in shutdown");
    property p_go; adcStart |-> $past(adcEnable); endproperty
    a_go: assert property (p_go)
        else $error("start while powered down");
    // Converter follows the supplies
    property p_on;
        (refEnable && (highSupplyUvOk || lowSupplyRailUvOk))[*8]
        |-> adcEnable;
    endproperty
    a_on: assert property (p_on)
        else $error("converter off, supply up");
    property p_off;
        (!highSupplyUvOk && !lowSupplyRailUvOk)[*5] |-> !adcEnable;
    endproperty
    a_off: assert property (p_off)
        else $error("converter on, supplies down");
    // Legal channels, spaced starts
    property p_ch; adcStart |-> adcChannel != 2'h3; endproperty
    a_ch: assert property (p_ch)
        else $error("illegal channel");
    property p_gap; adcStart |=> !adcStart [*3]; endproperty
    a_gap: assert property (p_gap)
        else $error("starts too close");
    // Answer moves only with clock low
    property p_oe; $changed(sdaOe) |-> !scl; endproperty
    a_oe: assert property (p_oe)
        else $error("data moved with clock high");
endmodule

bind power_monitor_adc_sequencer pmon_props u_pmon_props (.*);

// ===== i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
    // Bus pins
    output logic scl,
    output logic pull,
    input wire sda
);
    // Idle: clock high, data released
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // One bit; the long low phase leaves time to answer
    task bitx(input logic v, output logic r);
        #200 pull = !v;
        #300 scl = 1'b1;
        r = sda;
        #300 scl = 1'b0;
    endtask
    // Start (or repeated start) if s, else stop
    task cond(input logic s);
        #200 pull = !s;
        #300 scl = 1'b1;
        #300 pull = s;
        #400 scl = !s;
    endtask
    // Eight bits, ninth a; q and n take the wire
    task xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
        output logic n);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(a, n);
    endtask
endmodule

// ===== power_monitor_adc_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module power_monitor_adc_sequencer_tb;
    localparam logic [6:0] ADDR = 7'h64;
    logic core_clk, sys_rst, scl, pull, sdaOut, sdaOe, adcStart, adcDone;
    logic uvHigh, uvLow, adcEnable, refEnable, regulatorEnable, sense;
    logic [1:0] hiSel, loSel, adcChannel;
    logic [11:0] adcData;
    logic [7:0] v, q[$], vs[3] = '{8'h05, 8'h01, 8'h04};
    int miscompares, checks_done, tn, cyc, cnt, ch, sn, snap, sg, n;
    int starts, prv = -1, sel = 1, pw, res[3];
    event scanEnd, convEnd;
    wire sda = !(pull || (sdaOe && !sdaOut));
    power_monitor_adc_sequencer u_power_monitor_adc_sequencer (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
        .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addressSelectPinHigh(hiSel), .addressSelectPinLow(loSel),
        .highSupplyUvOk(uvHigh), .lowSupplyRailUvOk(uvLow),
        .highSupplyBusOk(uvHigh), .lowSupplyRailBusOk(uvLow),
        .adcStart(adcStart), .adcChannel(adcChannel),
        .adcSupplySense(sense), .adcDone(adcDone), .adcData(adcData),
        .adcEnable(adcEnable), .refEnable(refEnable),
        .regulatorEnable(regulatorEnable));
    i2c_host_model host (.scl(scl), .pull(pull), .sda(sda));
    initial
    begin
        core_clk = 0;
        forever #50 core_clk = !core_clk;
    end
    // Hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    // Converter stand-in; power loss drops its work
    always @(negedge core_clk)
    begin
        if (!adcEnable)
        begin
            cnt = 0;
            prv = -1;
        end
        adcDone <= cnt == 1;
        if (cnt == 1)
        begin
            res[ch] = $urandom % 4096;
            adcData <= 12'(res[ch]);
            if (ch == 2 && !sn)
            begin
                pw = res[0] * res[sel];
                -> scanEnd;
            end
            -> convEnd;
        end
        if (cnt > 0)
            cnt--;
        if (adcStart)
        begin
            if (!snap && prv >= 0)
                `CHK("order", (prv + 1) % 3, adcChannel)
            ch = adcChannel;
            sn = snap;
            prv = snap ? -1 : ch;
            sg += snap;
            starts++;
            cnt = 1200;
        end
    end
    ////////////////////////////////////////
    // Expected byte i from the power high byte
    function automatic logic [7:0] eb(int i);
        int r;
        if (i < 3)
            return 8'(pw >> (16 - 8 * i));
        r = res[(i - 3) / 2];
        return 8'(i % 2 ? r >> 4 : r << 4);
    endfunction
    // Write q at p, or read n bytes into q
    task acc(input logic rd, input logic [5:0] p, input int n);
        logic [7:0] b;
        logic a;
        host.cond(1);
        host.xfer({ADDR, 1'b0}, 1, b, a);
        `CHK("ack", 1'b0, a)
        host.xfer({2'b00, p}, 1, b, a);
        if (rd)
        begin
            host.cond(1);
            host.xfer({ADDR, 1'b1}, 1, b, a);
            q = {};
            for (int i = 0; i < n; i++)
            begin
                host.xfer(8'hff, i == n - 1, b, a);
                q.push_back(b);
            end
        end
        else
            foreach (q[i]) host.xfer(q[i], 1, b, a);
        host.cond(0);
    endtask
    task chkRes;
        acc(1, 6'h01, 9);
        foreach (q[i]) `CHK("result", eb(i), q[i])
    endtask
    task endt;
        tn++;
        $display("test %0d done", tn);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'haf06));
        sys_rst = 1;
        uvHigh = 1;
        uvLow = 0;
        hiSel = 2'h1;
        loSel = 2'h1;
        adcDone = 0;
        adcData = 12'h000;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) sys_rst = 0;
        repeat (10) @(negedge core_clk);
        acc(1, 6'h00, 1);
        `CHK("ctrl", 8'h05, q[0])
        foreach (vs[k])
        begin
            sel = vs[k] == 8'h04 ? 2 : 1;
            q = {vs[k]};
            acc(0, 6'h00, 0);
            repeat (2) @scanEnd;
            `CHK("sense", vs[k] != 8'h01, sense)
            chkRes();
            endt();
        end
        // Snapshot per code; model mode set at the stop
        for (int c = 0; c < 4; c++)
        begin
            v = 8'h85 | 8'(c << 5);
            q = {v};
            fork
                acc(0, 6'h00, 0);
                @(negedge pull iff scl) snap = 1;
            join
            wait (sg == c + 1);
            `CHK("snap ch", c % 3, adcChannel)
            acc(1, 6'h00, 1);
            `CHK("busy", v | 8'h08, q[0])
            @convEnd;
            n = starts;
            repeat (20) @(negedge core_clk);
            acc(1, 6'h00, 1);
            `CHK("done", v, q[0])
            chkRes();
            `CHK("halt", n, starts)
            endt();
        end
        snap = 0;
        q = {8'h07};
        acc(0, 6'h00, 0);
        @(negedge core_clk);
        {hiSel, loSel} = 4'h2;
        `CHK("off", 3'b000, {adcEnable, refEnable, regulatorEnable})
        q = {8'ha5, 8'h5f};
        acc(0, 6'h08, 0);
        acc(1, 6'h08, 2);
        `CHK("aux", 16'ha550, {q[0], q[1]})
        {hiSel, loSel} = 4'h5;
        q = {8'h05};
        acc(0, 6'h00, 0);
        acc(1, 6'h08, 2);
        `CHK("kept", 16'ha550, {q[0], q[1]})
        @(negedge core_clk) uvHigh = 0;
        repeat (10) @(negedge core_clk);
        `CHK("uv off", 1'b0, adcEnable)
        uvLow = 1;
        repeat (10) @(negedge core_clk);
        `CHK("uv on", 1'b1, adcEnable)
        endt();
        give_verdict();
    end
endmodule
